// file: mlda_aligner.sv
`timescale 1ns/1ns
`default_nettype none
module mlda_aligner #(
    parameter int NUM_LANES  = 4,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                         clk_sys,
    input  wire logic                         reset,
    input  wire logic [mlda_pkg::REG_AW-1:0]  regAddr,
    input  wire logic [31:0]                  regWrData,
    input  wire logic                         regWr,
    input  wire logic                         regRd,
    output logic      [31:0]                  regRdData,
    input  wire logic                         deskewReq,
    output logic                              alignOk,
    input  wire logic [NUM_LANES-1:0]         clkLane,
    input  wire mlda_pkg::mlda_word_t         laneDec   [NUM_LANES],
    input  wire mlda_pkg::mlda_word_t         laneWal   [NUM_LANES],
    output mlda_pkg::mlda_word_t              alignData [NUM_LANES],
    output logic                              alignValid
);
    localparam int AW = $clog2(FIFO_DEPTH);

    // ========================================================================
    // Pattern compare over the lane window; masked or unused bytes always pass.
    function automatic logic patMatch(input mlda_pkg::mlda_win_t w, input logic [2:0] st,
                                      input logic [2:0] nUse, input logic [3:0] mask,
                                      input mlda_pkg::mlda_pat_t pat);
        logic       ok;
        logic [3:0] idx;
        ok = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            idx = {1'b0, st} + 4'(i);
            if (3'(i) < nUse && !mask[i] && idx < 4'h8 && w[idx[2:0]] != pat[i]) // RQ9 RQ10
                ok = 1'b0;
        end
        return ok;
    endfunction

    // ========================================================================
    // Register file.
    logic [31:0] ctrl_q;
    logic [31:0] priLo_q;
    logic [31:0] priHi_q;
    logic [31:0] secLo_q;
    logic [31:0] secHi_q;
    logic [31:0] rdData_q;
    logic [31:0] statusWord;
    wire         wrCtrl  = regWr && regAddr == mlda_pkg::OFF_CTRL;
    wire         wrPriLo = regWr && regAddr == mlda_pkg::OFF_PRI_LO;
    wire         wrPriHi = regWr && regAddr == mlda_pkg::OFF_PRI_HI;
    wire         wrSecLo = regWr && regAddr == mlda_pkg::OFF_SEC_LO;
    wire         wrSecHi = regWr && regAddr == mlda_pkg::OFF_SEC_HI;
    wire  [31:0] rdMux   = regAddr == mlda_pkg::OFF_CTRL   ? ctrl_q :
                           regAddr == mlda_pkg::OFF_PRI_LO ? priLo_q :
                           regAddr == mlda_pkg::OFF_PRI_HI ? priHi_q :
                           regAddr == mlda_pkg::OFF_SEC_LO ? secLo_q :
                           regAddr == mlda_pkg::OFF_SEC_HI ? secHi_q :
                           regAddr == mlda_pkg::OFF_STATUS ? statusWord : 32'h0000_0000;

    // Writes land on the strobe edge; unmapped addresses are ignored.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q  <= mlda_pkg::CTRL_RESET;
            priLo_q <= mlda_pkg::PAT_RESET;
            priHi_q <= mlda_pkg::PAT_RESET;
            secLo_q <= mlda_pkg::PAT_RESET;
            secHi_q <= mlda_pkg::PAT_RESET;
        end
        else
        begin
            if (wrCtrl)  ctrl_q  <= regWrData;
            if (wrPriLo) priLo_q <= regWrData;
            if (wrPriHi) priHi_q <= regWrData;
            if (wrSecLo) secLo_q <= regWrData;
            if (wrSecHi) secHi_q <= regWrData;
        end
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            rdData_q <= 32'h0000_0000;
        else
            rdData_q <= regRd ? rdMux : 32'h0000_0000;
    end
    assign regRdData = rdData_q;

    // Configuration as seen by the lanes; change it only while no session runs.
    mlda_pkg::mlda_cfg_t cfgSys;
    wire [3:0] maxSkew = ctrl_q[mlda_pkg::CTRL_SKEW +: 4];
    assign cfgSys.enable    = ctrl_q[mlda_pkg::CTRL_EN];
    assign cfgSys.twoByte   = ctrl_q[mlda_pkg::CTRL_TWO];
    assign cfgSys.decBypass = ctrl_q[mlda_pkg::CTRL_BYP];
    assign cfgSys.secEn     = ctrl_q[mlda_pkg::CTRL_SEC];
    assign cfgSys.patLen    = mlda_pkg::mlda_len_t'(ctrl_q[mlda_pkg::CTRL_LEN +: 2]);
    assign cfgSys.mask      = ctrl_q[mlda_pkg::CTRL_MASK +: 4];
    assign cfgSys.priPat    = {priHi_q[mlda_pkg::PAT_HI_SYM +: mlda_pkg::SYM_W],
                               priHi_q[mlda_pkg::SYM_W-1:0],
                               priLo_q[mlda_pkg::PAT_HI_SYM +: mlda_pkg::SYM_W],
                               priLo_q[mlda_pkg::SYM_W-1:0]};
    assign cfgSys.secPat    = {secHi_q[mlda_pkg::PAT_HI_SYM +: mlda_pkg::SYM_W],
                               secHi_q[mlda_pkg::SYM_W-1:0],
                               secLo_q[mlda_pkg::PAT_HI_SYM +: mlda_pkg::SYM_W],
                               secLo_q[mlda_pkg::SYM_W-1:0]};

    // ========================================================================
    // Session control on the common clock.
    mlda_pkg::mlda_state_t state_q;
    mlda_pkg::mlda_state_t state_d;
    logic                  req_q;
    logic                  sessTgl_q;
    logic                  alignOk_q;
    logic                  skewFail_q;
    logic                  ovfl_q;
    logic                  valid_q;
    logic [AW-1:0]         rp_q;
    logic [NUM_LANES-1:0]  laneFound;
    logic [NUM_LANES-1:0]  laneAvail;
    logic [NUM_LANES-1:0]  laneLate;
    logic [NUM_LANES-1:0]  laneFull;
    wire  reqRise  = deskewReq && !req_q;
    wire  newSess  = reqRise && cfgSys.enable;
    wire  allFound = &laneFound;
    wire  skewErr  = |laneLate && !allFound;
    // A restart edge reads nothing, so a fresh search never shows a stale word.
    wire  readRun  = state_q == mlda_pkg::ST_RUN && &laneAvail && !newSess;

    // Next state: a rising request restarts while enabled, a falling one ends a search.
    always_comb
    begin
        state_d = state_q;
        if (newSess)                                       // RQ14 RQ17
            state_d = mlda_pkg::ST_SEEK;
        else if (state_q == mlda_pkg::ST_SEEK)
        begin
            if (!deskewReq)
                state_d = mlda_pkg::ST_IDLE;
            else if (skewErr)                              // RQ11
                state_d = mlda_pkg::ST_FAIL;
            else if (allFound)                             // RQ5
                state_d = mlda_pkg::ST_RUN;
        end
    end

    // Session registers; a restart clears sticky errors unless an error sets them now.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q    <= mlda_pkg::ST_IDLE;
            req_q      <= 1'b0;
            sessTgl_q  <= 1'b0;
            alignOk_q  <= 1'b0;
            skewFail_q <= 1'b0;
            ovfl_q     <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            req_q      <= deskewReq;
            sessTgl_q  <= sessTgl_q ^ newSess;             // RQ17
            alignOk_q  <= deskewReq && !newSess &&
                          (alignOk_q || state_d == mlda_pkg::ST_RUN &&
                           state_q == mlda_pkg::ST_SEEK);  // RQ16
            skewFail_q <= (skewFail_q && !newSess) || (state_q == mlda_pkg::ST_SEEK && skewErr);
            ovfl_q     <= (ovfl_q && !newSess) || |laneFull;  // RQ19
        end
    end

    // One read pointer serves every lane, so all lanes leave in step.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rp_q    <= '0;
            valid_q <= 1'b0;
        end
        else
        begin
            if (newSess)
                rp_q <= '0;                                // RQ3
            else if (readRun)
                rp_q <= rp_q + 1'b1;                       // RQ5
            valid_q <= readRun;
        end
    end
    assign alignOk    = alignOk_q;
    assign alignValid = valid_q;
    assign statusWord = {16'h0000, 8'(laneFound), 4'h0, valid_q, ovfl_q, skewFail_q, alignOk_q};

    // ========================================================================
    // Per-lane window, detection and deskew FIFO.
    for (genvar g = 0; g < NUM_LANES; g++)
    begin : gLane
        logic [1:0]          rstSh_q;
        mlda_pkg::mlda_cfg_t cfgS1_q;
        mlda_pkg::mlda_cfg_t cfgS2_q;
        logic [2:0]          sess_q;
        logic                ack_q;
        logic                seek_q;
        logic                detect_q;
        logic                wrOn_q;
        logic                found_q;
        logic [2:0]          tap_q;
        logic [AW-1:0]       wp_q;
        logic [AW-1:0]       wp_d;
        logic [AW-1:0]       wpG_q;
        logic [mlda_pkg::SYM_W-1:0] hist_q [mlda_pkg::HIST];
        mlda_pkg::mlda_word_t mem_q [FIFO_DEPTH];
        mlda_pkg::mlda_win_t  win;
        logic [2:0]          nUse;
        logic                hitLate;
        logic                hitEarly;
        logic [2:0]          stHit;
        logic [2:0]          tapHit;
        wire                 rstL    = rstSh_q[1];
        wire                 two     = cfgS2_q.twoByte;
        wire                 sessNew = sess_q[2] ^ sess_q[1];
        wire                 hit     = seek_q && (hitLate || hitEarly);
        wire                 wrEn    = detect_q || wrOn_q;
        wire mlda_pkg::mlda_word_t inWord = cfgS2_q.decBypass ? laneWal[g] : laneDec[g]; // RQ7
        wire [2:0]           stLate  = 3'(4'h8 - {1'b0, nUse});
        wire [2:0]           stEarly = stLate - 3'h1;
        wire mlda_pkg::mlda_word_t wrWord =
            two ? {win[3'(tap_q + 3'h1)], win[tap_q]} : {{mlda_pkg::SYM_W{1'b0}}, win[tap_q]};

        // Reset release and configuration are brought onto the lane clock.
        always_ff @(posedge clkLane[g] or posedge reset)
        begin
            if (reset)
            begin
                rstSh_q <= 2'b11;
                cfgS1_q <= '0;
                cfgS2_q <= '0;
            end
            else
            begin
                rstSh_q <= {rstSh_q[0], 1'b0};
                cfgS1_q <= cfgSys;
                cfgS2_q <= cfgS1_q;
            end
        end

        // Oldest symbol at index 0; two-byte mode takes byte 0 before byte 1.
        always_comb
        begin
            for (int i = 0; i < 6; i++)
                win[i] = two ? hist_q[i + 1] : hist_q[i];
            win[6] = two ? inWord[0] : hist_q[6];
            win[7] = two ? inWord[1] : inWord[0];
        end

        // Matches ending on the newest symbol or, in two-byte mode, one before it.
        assign nUse     = cfgS2_q.patLen == mlda_pkg::LEN1 ? 3'h1 :
                          cfgS2_q.patLen == mlda_pkg::LEN2 ? 3'h2 : 3'h4;  // RQ9
        assign hitLate  = patMatch(win, stLate, nUse, cfgS2_q.mask, cfgS2_q.priPat) ||
                          (cfgS2_q.secEn &&
                           patMatch(win, stLate, nUse, cfgS2_q.mask, cfgS2_q.secPat)); // RQ8
        assign hitEarly = two &&
                          (patMatch(win, stEarly, nUse, cfgS2_q.mask, cfgS2_q.priPat) ||
                           (cfgS2_q.secEn &&
                            patMatch(win, stEarly, nUse, cfgS2_q.mask, cfgS2_q.secPat)));
        // The tap trails the start by one word; an odd tap pairs bytes shifted by one.
        assign stHit    = hitEarly ? stEarly : stLate;
        assign tapHit   = stHit - (two ? 3'h2 : 3'h1);     // RQ13
        assign wp_d     = (hit && !sessNew) ? '0 : (wrEn && !sessNew) ? wp_q + 1'b1 : wp_q;

        // Window history shifts by one symbol or one word per lane clock.
        always_ff @(posedge clkLane[g])
        begin
            for (int i = 0; i < mlda_pkg::HIST; i++)
                hist_q[i] <= win[i + 1];
        end

        // Lane search; the found level rises two edges after the pointer jump,
        // so the common side never samples a pointer mid-jump.
        always_ff @(posedge clkLane[g] or posedge rstL)
        begin
            if (rstL)
            begin
                sess_q   <= 3'b000;
                ack_q    <= 1'b0;
                seek_q   <= 1'b0;
                detect_q <= 1'b0;
                wrOn_q   <= 1'b0;
                found_q  <= 1'b0;
                tap_q    <= 3'h0;
                wp_q     <= '0;
                wpG_q    <= '0;
            end
            else
            begin
                sess_q <= {sess_q[1:0], sessTgl_q};
                ack_q  <= sess_q[2];
                wp_q   <= wp_d;                            // RQ3 RQ4
                wpG_q  <= wp_d ^ (wp_d >> 1);
                if (sessNew)
                begin
                    seek_q   <= cfgS2_q.enable;
                    detect_q <= 1'b0;
                    wrOn_q   <= 1'b0;
                    found_q  <= 1'b0;
                end
                else
                begin
                    if (hit)
                    begin
                        seek_q   <= 1'b0;
                        detect_q <= 1'b1;
                        tap_q    <= tapHit;
                    end
                    else
                        detect_q <= 1'b0;
                    if (detect_q)
                        wrOn_q <= 1'b1;
                    found_q <= found_q || wrOn_q;
                end
            end
        end

        // Written on the lane clock only; read below on the common clock.
        always_ff @(posedge clkLane[g])
        begin
            if (wrEn)
                mem_q[wp_q] <= wrWord;                     // RQ2
        end

        // Common side: found, session echo and write pointer each pass two flops.
        logic          fS1_q;
        logic          fS2_q;
        logic          aS1_q;
        logic          aS2_q;
        logic [AW-1:0] gS1_q;
        logic [AW-1:0] gS2_q;
        logic [AW-1:0] wpBin;
        mlda_pkg::mlda_word_t out_q;
        always_ff @(posedge clk_sys or posedge reset)
        begin
            if (reset)
            begin
                {fS1_q, fS2_q, aS1_q, aS2_q} <= 4'h0;
                gS1_q <= '0;
                gS2_q <= '0;
                out_q <= '0;
            end
            else
            begin
                {fS1_q, fS2_q, aS1_q, aS2_q} <= {found_q, fS1_q, ack_q, aS1_q};
                gS1_q <= wpG_q;
                gS2_q <= gS1_q;
                if (readRun)
                    out_q <= mem_q[rp_q];                  // RQ1 RQ4
            end
        end

        // Gray to binary, then the lane's view of found, data present and skew.
        always_comb
        begin
            wpBin[AW-1] = gS2_q[AW-1];
            for (int i = AW - 2; i >= 0; i--)
                wpBin[i] = wpBin[i + 1] ^ gS2_q[i];
        end
        assign laneFound[g] = fS2_q && aS2_q == sessTgl_q;
        assign laneAvail[g] = wpBin != rp_q;
        assign laneLate[g]  = laneFound[g] && {1'b0, wpBin} >
                              (AW + 1)'({1'b0, maxSkew} + {1'b0, mlda_pkg::SKEW_BASE}); // RQ11
        assign laneFull[g]  = laneFound[g] && AW'(wpBin - rp_q) == AW'(FIFO_DEPTH - 1);
        assign alignData[g] = out_q;

        a_ptr_clear: assert property (@(posedge clkLane[g]) disable iff (rstL) // RQ3
            hit && !sessNew |=> wp_q == '0 ##1 wp_q == AW'(1))
            else $error("Write pointer not cleared on first pattern.");
        a_wp_advance: assert property (@(posedge clkLane[g]) disable iff (rstL) // RQ4
            wrOn_q && !sessNew |=> wp_q == AW'($past(wp_q) + 1'b1))
            else $error("Write pointer did not advance.");
        a_shift_odd: assert property (@(posedge clkLane[g]) disable iff (rstL) // RQ13
            hit && !sessNew && two && hitEarly && nUse != 3'h1 |=> tap_q[0])
            else $error("Upper byte start not shifted.");
        c_shifted: cover property (@(posedge clkLane[g]) disable iff (rstL)
            hit && two && tapHit[0]);
    end

    // ========================================================================
    // Checks on the common clock.
    default clocking cbSys @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_req_start: assert property (newSess |=> state_q == mlda_pkg::ST_SEEK ##0 rp_q == '0) // RQ14
        else $error("Request edge did not start a session.");
    a_sess_fresh: assert property (newSess |=> sessTgl_q != $past(sessTgl_q) && !alignOk) // RQ17
        else $error("Restart did not open a new session.");
    a_flag_drop: assert property (!deskewReq |=> !alignOk)                      // RQ16
        else $error("Aligned flag stayed high after request fell.");
    a_flag_cause: assert property ($rose(alignOk) |-> state_q == mlda_pkg::ST_RUN
                                   && $past(allFound))                          // RQ5
        else $error("Aligned flag without all lanes found.");
    a_rd_hold: assert property (state_q == mlda_pkg::ST_SEEK |-> rp_q == '0 &&
                                !alignValid ##1 $stable(alignData[0]))          // RQ4
        else $error("Read side moved before alignment.");
    a_rd_step: assert property (readRun |=> rp_q == AW'($past(rp_q) + 1'b1) && alignValid) // RQ5
        else $error("Read pointer did not step.");
    a_skew_fail: assert property (state_q == mlda_pkg::ST_SEEK && skewErr && deskewReq
                                  && !newSess |=> state_q == mlda_pkg::ST_FAIL
                                  ##0 statusWord[1])                            // RQ11
        else $error("Skew beyond limit not reported.");
    a_all_found: assert property (state_q == mlda_pkg::ST_SEEK && allFound && !skewErr &&
                                  deskewReq && !newSess |=> alignOk [*2])       // RQ1
        else $error("All lanes found but no alignment.");

    c_aligned: cover property (state_q == mlda_pkg::ST_SEEK ##1 state_q == mlda_pkg::ST_RUN);
    c_fail: cover property (state_q == mlda_pkg::ST_FAIL);
    c_drop_run: cover property (alignOk ##1 !deskewReq ##1 alignValid);
    c_restart: cover property (alignOk ##1 !deskewReq ##1 newSess);

endmodule
`default_nettype wire

// file: mlda_aligner_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mlda_aligner_tb;
    localparam int NL = 2;
    logic clk_sys = 0, reset = 1, regWr = 0, regRd = 0, go = 0, dropOnOk = 0, byp = 0;
    logic [7:0]  regAddr   = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, d, ctl;
    logic deskewReq, alignOk, alignValid;
    logic [NL-1:0] clkLane = '0;
    logic [9:0] patVal = 10'h17C;
    mlda_pkg::mlda_word_t laneDec [NL] = '{default: '0};
    mlda_pkg::mlda_word_t laneWal [NL] = '{default: '0};
    mlda_pkg::mlda_word_t alignData [NL];
    int laneCnt [NL] = '{default: 0};
    int patBase = 1000000, n_fail = 0, checks = 0, seed = 32'h3242;

    mlda_aligner #(.NUM_LANES(NL), .FIFO_DEPTH(16)) i_mlda_aligner (.clk_sys(clk_sys),
        .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .deskewReq(deskewReq), .alignOk(alignOk),
        .clkLane(clkLane), .laneDec(laneDec), .laneWal(laneWal),
        .alignData(alignData), .alignValid(alignValid));
    mlda_user_model i_mlda_user_model (.clk_sys(clk_sys), .reset(reset), .go(go),
        .dropOnOk(dropOnOk), .alignOk(alignOk), .deskewReq(deskewReq));

    // Lane word for a count: filler below the pattern value, the pattern, then a count.
    function automatic mlda_pkg::mlda_word_t laneWord(input int c, input int b);
        return {10'h000, (c < b) ? 10'($random(seed)) & 10'h0FF
                       : (c == b) ? patVal : 10'(c - b)};
    endfunction
    // Expected aligned word k of a session: the pattern first, then the count.
    function automatic logic [31:0] expWord(input int k);
        return {22'h0, (k == 0) ? patVal : 10'(k)};
    endfunction

    // ====
    // Clocks; lane clocks are offset so no lane shares a phase with another.
    initial forever #5 clk_sys = ~clk_sys;
    for (genvar g = 0; g < NL; g++)
    begin : gLane
        initial
        begin
            #(3 + 17 * g);
            forever #40 clkLane[g] = ~clkLane[g];
        end
        // The stream feeds the bypass input only while the session asks for it.
        mlda_pkg::mlda_word_t w;
        always @(posedge clkLane[g])
        begin
            w = laneWord(laneCnt[g], patBase + 3 * g);
            laneCnt[g] <= laneCnt[g] + 1;
            laneDec[g] <= byp ? '0 : w;
            laneWal[g] <= byp ? w : '0;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Bounded wait; running out counts as a mismatch and closes the run.
    task automatic waitVal(ref logic s, input logic v);
        for (int i = 0; i < 3000 && s !== v; i++)
            @(posedge clk_sys);
        if (s !== v)
        begin
            n_fail++;
            $display("CHECK FAILED wait expected %b seen %b", v, s);
            tally_and_finish();
        end
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [31:0] v);
        regAddr   <= a;
        regWrData <= v;
        regWr     <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic regRead(input logic [7:0] a);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdData;
        @(posedge clk_sys);
    endtask

    // ====
    // Two sessions: hold mode on primary, then drop mode on a two-byte secondary
    // with byte 1 masked, fed through the bypass input.
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (30) @(posedge clk_sys);
        for (int s = 0; s < 2; s++)
        begin
            patVal = s ? 10'h1F0 : 10'h17C;
            ctl    = s ? 32'h000A_021D : 32'h000A_0001;
            byp    = s[0];
            regWrite(8'h04, s ? 32'h2AA : {22'h0, patVal});
            regWrite(8'h0C, {22'h0, patVal});
            regWrite(8'h00, ctl);
            regRead(8'h00);
            chk("ctrl", ctl, d);
            regRead(8'h40);
            chk("unmapped", 32'h0, d);
            dropOnOk <= s[0];
            go       <= 1'b1;
            patBase = laneCnt[0] + 12;
            waitVal(alignOk, 1'b1);
            waitVal(alignValid, 1'b1);
            for (int k = 0; k < 5; k++)
            begin
                chk("lane0", expWord(k), alignData[0]);
                chk("lane1", expWord(k), alignData[1]);
                @(posedge clk_sys);
                waitVal(alignValid, 1'b1);
            end
            regRead(8'h14);
            chk("status", {31'h0, ~s[0]}, {31'h0, d[0]});
            go <= 1'b0;
            repeat (3) @(posedge clk_sys);
            chk("alignOk", 32'h0, {31'h0, alignOk});
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: mlda_pkg.sv
// ============================================================================
// How it works
// RQ1: Lanes cross into one clock, leave aligned.
// RQ2: FIFO written by lane clock, read by common clock.
// RQ3: First pattern clears write and read pointers.
// RQ4: Write pointer advances; read holds, output repeats.
// RQ5: All lanes found: read advances every cycle; the code advances only in cycles where every lane has data.
// RQ6: Software disables aligner for single lane links.
// RQ7: One or two byte words; decoder or aligner source.
// RQ8: Primary and optional secondary four byte patterns.
// RQ9: Length 1, 2 or 4 selects compared bytes.
// RQ10: Mask bit set ignores matching pattern byte.
// RQ11: Skew up to ten, limit programmable lower.
// RQ12: Software sets limit to skew plus margin.
// RQ13: Two byte mode moves pattern start to low byte.
// RQ14: Request rising edge starts an alignment session.
// RQ15: Request held, or dropped after aligned flag rises.
// RQ16: Aligned flag high with request, drops after release.
// RQ17: Request low then high starts fresh session.
// RQ18: User logic may retrigger on lost alignment.
// RQ19: FIFO deep enough for skew plus margin.
package mlda_pkg;

    // ========================================================================
    // Widths and register map.
    localparam int        SYM_W         = 10;
    localparam int        WIN           = 8;
    localparam int        HIST          = 7;
    localparam int        REG_AW        = 8;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_PRI_LO   = 8'h04;
    localparam logic [7:0] OFF_PRI_HI   = 8'h08;
    localparam logic [7:0] OFF_SEC_LO   = 8'h0C;
    localparam logic [7:0] OFF_SEC_HI   = 8'h10;
    localparam logic [7:0] OFF_STATUS   = 8'h14;

    // ========================================================================
    // Control field positions and reset values.
    localparam int        CTRL_EN       = 0;
    localparam int        CTRL_TWO      = 1;
    localparam int        CTRL_BYP      = 2;
    localparam int        CTRL_SEC      = 3;
    localparam int        CTRL_LEN      = 4;
    localparam int        CTRL_MASK     = 8;
    localparam int        CTRL_SKEW     = 16;
    localparam int        PAT_HI_SYM    = 16;
    localparam int        ST_FOUND      = 8;
    localparam logic [31:0] CTRL_RESET  = 32'h000A_0000;
    localparam logic [31:0] PAT_RESET   = 32'h0000_0000;
    localparam logic [3:0] SKEW_BASE    = 4'h2;

    // ========================================================================
    // Types.
    typedef enum logic [1:0] {
        LEN1 = 2'b00,
        LEN2 = 2'b01,
        LEN4 = 2'b10
    } mlda_len_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEEK = 2'b01,
        ST_RUN  = 2'b10,
        ST_FAIL = 2'b11
    } mlda_state_t;

    typedef logic [1:0][SYM_W-1:0]     mlda_word_t;
    typedef logic [WIN-1:0][SYM_W-1:0] mlda_win_t;
    typedef logic [3:0][SYM_W-1:0]     mlda_pat_t;

    typedef struct packed {
        logic      enable;
        logic      twoByte;
        logic      decBypass;
        logic      secEn;
        mlda_len_t patLen;
        logic [3:0] mask;
        mlda_pat_t priPat;
        mlda_pat_t secPat;
    } mlda_cfg_t;

endpackage

// file: mlda_user_model.sv
`timescale 1ns/1ns
`default_nettype none
module mlda_user_model (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic go,
    input  wire logic dropOnOk,
    input  wire logic alignOk,
    output logic      deskewReq
);
    logic done_q;
    // ====
    // Request follows go; in drop mode it falls as soon as aligned is seen.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            deskewReq <= 1'b0;
            done_q    <= 1'b0;
        end
        else
        begin
            done_q    <= go & (done_q | (dropOnOk & alignOk));
            deskewReq <= go & ~done_q & ~(dropOnOk & alignOk);
        end
    end
endmodule
`default_nettype wire
